// [rtl/tsgp_pkg.sv]
`default_nettype none
package tsgp_pkg;
    localparam int          NUM_PINS       = 4;        // Pins 0..3 of the port
    localparam int          ADDR_W         = 8;        // Decoded APB address bits
    // Register byte offsets
    localparam logic [7:0]  OFF_LATCH      = 8'h00;    // port_output_latch
    localparam logic [7:0]  OFF_DIR        = 8'h04;    // port_direction
    localparam logic [7:0]  OFF_PULL       = 8'h08;    // port_pullup_select
    localparam logic [7:0]  OFF_TID        = 8'h0c;    // touch_input_disable
    localparam logic [7:0]  OFF_CTRL       = 8'h10;    // Standby and wake control
    localparam logic [7:0]  OFF_STAT       = 8'h14;    // Live status
    localparam logic [7:0]  OFF_LATCH_RMW  = 8'h18;    // Latch read as in read-modify-write
    // Control register field positions
    localparam int          CTRL_SPF       = 0;        // standby_pin_float
    localparam int          CTRL_TSE       = 1;        // touch_stop_enable
    localparam int          CTRL_TWI       = 2;        // touch_wake_interrupt enable
    localparam int          CTRL_GWI       = 3;        // general_wake_interrupt enable
    localparam int          CTRL_W         = 4;        // Control field width
    // Status register field positions
    localparam int          STAT_STBY      = 0;        // Stop or watch mode active
    localparam int          STAT_FLOAT     = 1;        // Pins forced to high impedance
    localparam int          STAT_WAKE      = 2;        // Wake request asserted
    // Reset values
    localparam logic [3:0]  RST_LATCH      = 4'h0;
    localparam logic [3:0]  RST_DIR        = 4'h0;
    localparam logic [3:0]  RST_PULL       = 4'h0;
    localparam logic [3:0]  RST_TID        = 4'h0;
    localparam logic [3:0]  RST_CTRL       = 4'h0;
    localparam logic [31:0] RST_RDATA      = 32'h0000_0000;
endpackage
`default_nettype wire

// [rtl/tsgp_port.sv]
// Function
// - Direction one drives latch onto pin
// - Latch write stored, output pins follow
// - Latch write on input pin not driven
// - Output pin read returns latch
// - Input read pin, RMW read latch
// - Direction zero disables output driver
// - Reset clears all direction bits
// - Reset clears all touch-disable bits
// - Float bit in standby forces high impedance
// - Floated pin input held low
// - Touch stop enable keeps touch inputs open
// - Touch wake needs both interrupt enables
// - Float bit zero keeps pins in standby
// - Pull-up bit connects pull-up resistor
// - Driving low disconnects pull-up
// - Bits 0..3 map pins, upper unused
// - Pins 0..3 feed touch channels 4..7
//
// The implementer's own choices: the address map and the APB register port.
`default_nettype none
module tsgp_port (
    input  wire logic        clk_i,          // 100 MHz machine clock
    input  wire logic        rst_n_i,        // Async reset, active low
    input  wire logic        psel_i,         // APB select
    input  wire logic        penable_i,      // APB enable
    input  wire logic        pwrite_i,       // APB direction
    input  wire logic [7:0]  paddr_i,        // APB byte address
    input  wire logic [31:0] pwdata_i,       // APB write data
    output logic      [31:0] prdata_o,       // APB read data
    output logic             pready_o,       // APB ready
    output logic             pslverr_o,      // APB error on unmapped address
    input  wire logic        standby_i,      // Stop or watch mode active
    input  wire logic        touch_irq_i,    // Touch sensor event
    input  wire logic [3:0]  pin_in_i,       // Pin levels
    output logic      [3:0]  pin_out_o,      // Pin drive value
    output logic      [3:0]  pin_oe_o,       // Pin driver enable
    output logic      [3:0]  pullup_en_o,    // Pull-up connect
    output logic      [3:0]  port_in_o,      // Gated port input to core
    output logic      [3:0]  touch_in_o,     // Touch channels 4..7 input
    output logic             wake_o          // Wake request from touch
);

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [3:0]  latch_ff, nxt_latch;        // port_output_latch
    logic [3:0]  dir_ff,   nxt_dir;          // port_direction
    logic [3:0]  pull_ff,  nxt_pull;         // port_pullup_select
    logic [3:0]  tid_ff,   nxt_tid;          // touch_input_disable
    logic [3:0]  ctrl_ff,  nxt_ctrl;         // Standby/wake control
    logic [31:0] rdata_ff, nxt_rdata;        // Read data
    logic        ready_ff, nxt_ready;        // Ready pulse
    logic        err_ff,   nxt_err;          // Error pulse
    logic        setup;                      // APB setup phase
    logic        access;                     // APB access phase
    logic        hit;                        // Address mapped
    logic [3:0]  port_rd;                    // Per-pin data read value
    logic [3:0]  wr4;                        // Low nibble of write data

    // Pin state
    logic [3:0]  samp_ff,  nxt_samp;         // Pin level sample
    logic [3:0]  out_ff,   nxt_out;
    logic [3:0]  oe_ff,    nxt_oe;
    logic [3:0]  pu_ff,    nxt_pu;
    logic [3:0]  pin_ff,   nxt_pin;
    logic [3:0]  tin_ff,   nxt_tin;
    logic        wake_ff,  nxt_wake;
    logic        floating;                   // Forced high impedance
    logic        touch_live;                 // Touch inputs unblocked

    assign setup    = psel_i & ~penable_i;
    assign access   = psel_i & penable_i;
    assign wr4      = pwdata_i[3:0];         // Upper bits dropped
    assign floating = standby_i & ctrl_ff[tsgp_pkg::CTRL_SPF];
    assign touch_live = ~standby_i | ctrl_ff[tsgp_pkg::CTRL_TSE];

    ////////////////////////////////////////////////////////////////////////
    // Per-pin read mux: output pins read latch, input pins read pin
    genvar g;
    generate
        for (g = 0; g < tsgp_pkg::NUM_PINS; g++) begin : g_rd
            assign port_rd[g] = dir_ff[g] ? latch_ff[g] : samp_ff[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // APB decode and register next state
    // One wait state: the first access cycle decodes and raises ready,
    // the next edge, where the master samples ready high, commits a write.
    // Committing late keeps a write from landing before the master has
    // seen its answer, at no cost in cycles, since ready rises at the same edge either way.
    always_comb begin
        nxt_latch = latch_ff;
        nxt_dir   = dir_ff;
        nxt_pull  = pull_ff;
        nxt_tid   = tid_ff;
        nxt_ctrl  = ctrl_ff;
        nxt_rdata = rdata_ff;
        nxt_ready = access & ~ready_ff;      // Ready for one cycle only
        nxt_err   = 1'b0;
        hit       = 1'b1;
        // Answer decided in the first access cycle, shown in the next
        if (access && !ready_ff) begin
            nxt_rdata = tsgp_pkg::RST_RDATA;
            case (paddr_i)
                tsgp_pkg::OFF_LATCH: begin
                    nxt_rdata[3:0] = port_rd;
                end
                tsgp_pkg::OFF_LATCH_RMW: begin
                    nxt_rdata[3:0] = latch_ff;                            // RMW view
                end
                tsgp_pkg::OFF_DIR: begin
                    nxt_rdata[3:0] = dir_ff;
                end
                tsgp_pkg::OFF_PULL: begin
                    nxt_rdata[3:0] = pull_ff;
                end
                tsgp_pkg::OFF_TID: begin
                    nxt_rdata[3:0] = tid_ff;
                end
                tsgp_pkg::OFF_CTRL: begin
                    nxt_rdata[3:0] = ctrl_ff;
                end
                tsgp_pkg::OFF_STAT: begin
                    nxt_rdata[tsgp_pkg::STAT_STBY]  = standby_i;
                    nxt_rdata[tsgp_pkg::STAT_FLOAT] = floating;
                    nxt_rdata[tsgp_pkg::STAT_WAKE]  = wake_ff;
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
            nxt_err = ~hit;
            if (pwrite_i) begin
                nxt_rdata = tsgp_pkg::RST_RDATA;  // Writes read back zero
            end
        end
        // Writes land at the edge where the master sees ready high
        if (access && ready_ff && pwrite_i) begin
            case (paddr_i)
                tsgp_pkg::OFF_LATCH,
                tsgp_pkg::OFF_LATCH_RMW: nxt_latch = wr4;
                tsgp_pkg::OFF_DIR:       nxt_dir   = wr4;
                tsgp_pkg::OFF_PULL:      nxt_pull  = wr4;
                tsgp_pkg::OFF_TID:       nxt_tid   = wr4;
                tsgp_pkg::OFF_CTRL:      nxt_ctrl  = wr4;
                default:                 nxt_latch = latch_ff;           // Unmapped or status: ignored
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            latch_ff <= tsgp_pkg::RST_LATCH;
            dir_ff   <= tsgp_pkg::RST_DIR;
            pull_ff  <= tsgp_pkg::RST_PULL;
            tid_ff   <= tsgp_pkg::RST_TID;
            ctrl_ff  <= tsgp_pkg::RST_CTRL;
            rdata_ff <= tsgp_pkg::RST_RDATA;
            ready_ff <= 1'b0;
            err_ff   <= 1'b0;
        end else begin
            latch_ff <= nxt_latch;
            dir_ff   <= nxt_dir;
            pull_ff  <= nxt_pull;
            tid_ff   <= nxt_tid;
            ctrl_ff  <= nxt_ctrl;
            rdata_ff <= nxt_rdata;
            ready_ff <= nxt_ready;
            err_ff   <= nxt_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin control next state, one generate slice per pin
    generate
        for (g = 0; g < tsgp_pkg::NUM_PINS; g++) begin : g_pin
            always_comb begin
                // Latch always on the pad; enable alone decides drive
                nxt_out[g] = latch_ff[g];
                // Drive only when output and not floated
                nxt_oe[g]  = dir_ff[g] & ~floating;
                // Pull-up off while driving low, also off when floated
                nxt_pu[g]  = pull_ff[g] & ~floating
                           & ~(dir_ff[g] & ~latch_ff[g]);
                // Port input path open only when disable bit set
                nxt_pin[g] = samp_ff[g] & tid_ff[g] & ~floating;
                // Touch channel 4+g sees pin when selected, input and live
                nxt_tin[g] = samp_ff[g] & ~tid_ff[g] & ~dir_ff[g]
                           & touch_live;
            end
        end
    endgenerate

    // Wake only with both enables and touch alive in standby
    always_comb begin
        nxt_samp = pin_in_i;
        nxt_wake = standby_i & touch_irq_i & ctrl_ff[tsgp_pkg::CTRL_TSE]
                 & ctrl_ff[tsgp_pkg::CTRL_TWI] & ctrl_ff[tsgp_pkg::CTRL_GWI];
    end

    // Pin flops; outputs come straight from here
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            samp_ff <= 4'h0;
            out_ff  <= 4'h0;
            oe_ff   <= 4'h0;
            pu_ff   <= 4'h0;
            pin_ff  <= 4'h0;
            tin_ff  <= 4'h0;
            wake_ff <= 1'b0;
        end else begin
            samp_ff <= nxt_samp;
            out_ff  <= nxt_out;
            oe_ff   <= nxt_oe;
            pu_ff   <= nxt_pu;
            pin_ff  <= nxt_pin;
            tin_ff  <= nxt_tin;
            wake_ff <= nxt_wake;
        end
    end

    assign prdata_o    = rdata_ff;
    assign pready_o    = ready_ff;
    assign pslverr_o   = err_ff;
    assign pin_out_o   = out_ff;
    assign pin_oe_o    = oe_ff;
    assign pullup_en_o = pu_ff;
    assign port_in_o   = pin_ff;
    assign touch_in_o  = tin_ff;
    assign wake_o      = wake_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // All run on the machine clock and sleep during reset, except the
    // reset check itself, which must look while reset is held.
    // Bus checks key off two points: the first access cycle, where the
    // answer is formed, and the commit edge, where ready is seen high.

    // First access cycle: slave decodes and raises ready next edge
    sequence s_acc_first;
        psel_i && penable_i && !pready_o;
    endsequence

    // Commit edge of a write: master samples ready high here
    sequence s_wr_commit;
        psel_i && penable_i && pready_o && pwrite_i;
    endsequence

    // Commit edge of a direction write
    sequence s_dir_wr;
        s_wr_commit ##0 paddr_i == tsgp_pkg::OFF_DIR;
    endsequence

    // Driver enable tracks direction one cycle later unless floated
    property p_oe_follow(int b);
        @(posedge clk_i) disable iff (!rst_n_i)
        ##1 pin_oe_o[b] == ($past(dir_ff[b], 1) && !$past(floating, 1));
    endproperty

    // Pin 0 drive enable follows its direction bit,
    // so a stuck or inverted enable shows at once
    output_drive_a: assert property (p_oe_follow(0))
        else $error("oe mismatch");

    // An input pin never drives
    input_nodrive_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !dir_ff[1] |=> !pin_oe_o[1])
        else $error("input pin driven");

    // Floated pins drop the driver and block the input,
    // whatever direction says
    float_hiz_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        floating |=> pin_oe_o == 4'h0 && port_in_o == 4'h0)
        else $error("float");

    // Written latch reaches the pad value unchanged
    latch_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_wr_commit ##0 paddr_i == tsgp_pkg::OFF_LATCH
        |=> ##1 pin_out_o == $past(pwdata_i[3:0], 2))
        else $error("latch");

    // Latch write on an input pin stores only,
    // the pin stays undriven
    latch_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_wr_commit ##0 (paddr_i == tsgp_pkg::OFF_LATCH && !dir_ff[0])
        |=> ##1 !pin_oe_o[0])
        else $error("input latch driven");

    // Direction takes the low nibble of the write
    dir_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_dir_wr |=> dir_ff == $past(pwdata_i[3:0]))
        else $error("dir write");

    // Plain data read picks latch or pin per direction
    read_mux_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_acc_first ##0 (!pwrite_i && paddr_i == tsgp_pkg::OFF_LATCH)
        |=> prdata_o == {28'h0, $past(port_rd)})
        else $error("read mux");

    // All inputs: a plain read shows the sampled pins
    input_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_acc_first ##0 (!pwrite_i && paddr_i == tsgp_pkg::OFF_LATCH && dir_ff == 4'h0)
        |=> prdata_o[3:0] == $past(samp_ff))
        else $error("input read");

    // Read-modify-write view always shows the latch,
    // so a bit update never copies pin levels back
    rmw_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_acc_first ##0 (!pwrite_i && paddr_i == tsgp_pkg::OFF_LATCH_RMW)
        |=> prdata_o == {28'h0, $past(latch_ff)})
        else $error("rmw read");

    // Unused upper bits always read zero
    upper_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pready_o |-> prdata_o[31:4] == 28'h0)
        else $error("upper bits");

    // Addresses beyond the map answer with an error
    err_unmapped_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_acc_first ##0 paddr_i > tsgp_pkg::OFF_LATCH_RMW |=> pslverr_o)
        else $error("no error");

    // Ready is a single pulse per transfer
    ready_once_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_acc_first |=> pready_o ##1 !pready_o)
        else $error("ready pulse");

    // No answer before the access phase
    no_early_ready_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        setup |-> !pready_o)
        else $error("early ready");

    // While reset is held, all pins are inputs
    // and the touch paths own every pin
    reset_clear_a: assert property (@(posedge clk_i)
        !rst_n_i |-> dir_ff == 4'h0 && tid_ff == 4'h0 && pin_oe_o == 4'h0)
        else $error("reset state");

    // Low output level never sees the pull-up
    pull_low_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pin_oe_o[2] && !pin_out_o[2] |-> !pullup_en_o[2])
        else $error("pullup low");

    // Pull-up bit on an input pin connects the resistor
    pull_connect_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pull_ff[1] && !dir_ff[1] && !floating |=> pullup_en_o[1])
        else $error("pullup off");

    // Floated pins also lose their pull-ups
    float_pull_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        floating |=> pullup_en_o == 4'h0)
        else $error("float pullup");

    // Entering standby without float keeps the drivers as they were
    standby_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(standby_i) && !floating && $stable(dir_ff) |=> pin_oe_o == $past(pin_oe_o))
        else $error("standby drive");

    // Touch inputs blocked in standby unless kept alive
    touch_block_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        standby_i && !ctrl_ff[tsgp_pkg::CTRL_TSE] |=> touch_in_o == 4'h0)
        else $error("touch open");

    // A pin feeds either the port input or its touch
    // channel, never both at once
    touch_excl_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (touch_in_o & port_in_o) == 4'h0)
        else $error("touch and port");

    // Wake needs the touch event and both enables
    wake_cause_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wake_o |-> $past(touch_irq_i) && $past(ctrl_ff[tsgp_pkg::CTRL_TWI])
        && $past(ctrl_ff[tsgp_pkg::CTRL_GWI]))
        else $error("wake cause");

    // Touch interrupt disabled: no wake at all
    wake_block_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !ctrl_ff[tsgp_pkg::CTRL_TWI] |=> !wake_o)
        else $error("wake blocked");

endmodule
`default_nettype wire

// [verif/tsgp_pin_model.sv]
`default_nettype none
module tsgp_pin_model (
    input  wire logic       clk_i,     // Machine clock
    input  wire logic [3:0] pin_out_i, // Design drive value
    input  wire logic [3:0] pin_oe_i,  // Design drive enable
    input  wire logic [3:0] pull_i,    // Pull-up connected
    input  wire logic [3:0] ext_en_i,  // External source active
    input  wire logic [3:0] ext_val_i, // External source level
    output logic      [3:0] pin_o      // Resolved pin level
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////
    logic [3:0] junk_ff; // Wandering level of a floating pin
    initial junk_ff = 4'h5;
    // Floating pins toggle so that a stale level never passes a check
    always @(posedge clk_i) begin
        junk_ff <= ~junk_ff;
    end
    // Design driver first, then outside source, then pull-up
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (pin_oe_i[i]) pin_o[i] = pin_out_i[i];
            else if (ext_en_i[i]) pin_o[i] = ext_val_i[i];
            else if (pull_i[i]) pin_o[i] = 1'b1;
            else pin_o[i] = junk_ff[i];
        end
    end
endmodule
`default_nettype wire

// [verif/touch_shared_gpio_port_test.sv]
`default_nettype none
module touch_shared_gpio_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////
    logic        clk_i, rst_n_i;       // Clock and reset
    logic        psel, penable, pwrite; // APB controls
    logic [7:0]  paddr;                // APB address
    logic [31:0] pwdata, prdata;       // APB data
    logic        pready, pslverr;      // APB response
    logic        standby, touch_irq;   // Mode and touch event
    logic [3:0]  pin_lvl, pin_out;     // Pin level and drive
    logic [3:0]  pin_oe, pull_en;      // Drive and pull-up enables
    logic [3:0]  port_in, touch_in;    // Core side inputs
    logic        wake;                 // Wake request
    logic [3:0]  ext_en, ext_val;      // Outside source
    logic [31:0] rd;                   // Last read data
    logic        err;                  // Last error response
    int          errors, num_checks;   // Counters
    ////////////////////////////////////////////////////////////////
    tsgp_port DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .standby_i(standby), .touch_irq_i(touch_irq),
        .pin_in_i(pin_lvl), .pin_out_o(pin_out), .pin_oe_o(pin_oe), .pullup_en_o(pull_en),
        .port_in_o(port_in), .touch_in_o(touch_in), .wake_o(wake));
    tsgp_pin_model pins (.clk_i(clk_i), .pin_out_i(pin_out), .pin_oe_i(pin_oe),
        .pull_i(pull_en), .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_o(pin_lvl));
    // 100 MHz clock
    always #5 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////
    // One APB transfer; waits for ready, bounded
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        // Values read here are those sampled at this edge
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Compare any result, zero extended
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // Reset pulse, then defaults; also used mid-run after setup
    task automatic t_reset(input int n);
        rst_n_i <= 1'b0;
        repeat (n) @(posedge clk_i);
        rst_n_i <= 1'b1;
        apb(0, tsgp_pkg::OFF_DIR, 0);
        chk(rd, 32'h0);
        apb(0, tsgp_pkg::OFF_TID, 0);
        chk(rd, 32'h0);
        chk({28'h0, pin_oe}, 32'h0);
        chk({28'h0, port_in}, 32'h0);
    endtask
    // Output pins carry the latch; upper bits dropped
    task automatic t_output();
        apb(1, tsgp_pkg::OFF_DIR, 32'hffff_ffff);
        apb(1, tsgp_pkg::OFF_LATCH, 32'hffff_ffa5);
        apb(1, tsgp_pkg::OFF_PULL, 32'hf);
        repeat (3) @(posedge clk_i);
        chk({28'h0, pin_oe}, 32'hf);
        chk({28'h0, pin_out}, 32'h5);
        apb(0, tsgp_pkg::OFF_LATCH, 0);
        chk(rd, 32'h5);
        chk({28'h0, pull_en}, 32'h5);
    endtask
    // Input pins: latch stored only, reads see pin or latch
    task automatic t_input();
        apb(1, tsgp_pkg::OFF_TID, 32'hf);
        apb(1, tsgp_pkg::OFF_DIR, 32'h0);
        apb(1, tsgp_pkg::OFF_LATCH, 32'hc);
        repeat (4) @(posedge clk_i);
        chk({28'h0, pin_oe}, 32'h0);
        chk({28'h0, port_in}, 32'h3);
        apb(0, tsgp_pkg::OFF_LATCH, 0);
        chk(rd, 32'h3);
        apb(0, tsgp_pkg::OFF_LATCH_RMW, 0);
        chk(rd, 32'hc);
        apb(1, tsgp_pkg::OFF_PULL, 32'hf);
        repeat (2) @(posedge clk_i);
        chk({28'h0, pull_en}, 32'hf);
    endtask
    // Standby with and without pin float
    task automatic t_standby();
        apb(1, tsgp_pkg::OFF_DIR, 32'hf);
        apb(1, tsgp_pkg::OFF_CTRL, 32'h1);
        standby <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk({28'h0, pin_oe}, 32'h0);
        chk({28'h0, port_in}, 32'h0);
        apb(1, tsgp_pkg::OFF_CTRL, 32'h0);
        repeat (3) @(posedge clk_i);
        chk({28'h0, pin_oe}, 32'hf);
        chk({28'h0, pin_out}, 32'hc);
        standby <= 1'b0;
    endtask
    // Touch channels, standby operation and wake enables
    task automatic t_touch();
        apb(1, tsgp_pkg::OFF_DIR, 32'h0);
        apb(1, tsgp_pkg::OFF_TID, 32'h0);
        apb(1, tsgp_pkg::OFF_PULL, 32'h0);
        ext_val <= 4'ha;
        apb(1, tsgp_pkg::OFF_CTRL, 32'he);
        standby <= 1'b1;
        touch_irq <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk({28'h0, touch_in}, 32'ha);
        chk({31'h0, wake}, 32'h1);
        apb(1, tsgp_pkg::OFF_CTRL, 32'h6);
        repeat (3) @(posedge clk_i);
        chk({31'h0, wake}, 32'h0);
        apb(1, tsgp_pkg::OFF_CTRL, 32'h0);
        repeat (3) @(posedge clk_i);
        chk({28'h0, touch_in}, 32'h0);
        standby <= 1'b0;
        touch_irq <= 1'b0;
        apb(1, 8'h1c, 32'hf);
        chk({31'h0, err}, 32'h1);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {clk_i, rst_n_i, psel, penable, pwrite, standby, touch_irq} = '0;
        {paddr, pwdata, errors, num_checks} = '0;
        ext_en = 4'hf;
        ext_val = 4'h3;
        t_reset(20);
        t_output();
        t_input();
        t_standby();
        t_touch();
        apb(1, tsgp_pkg::OFF_DIR, 32'hf);
        apb(1, tsgp_pkg::OFF_TID, 32'hf);
        t_reset(2);
        stop_test();
    end
    // Watchdog, far beyond the roughly 150 cycles needed
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        stop_test();
    end
endmodule
`default_nettype wire
